// File: hw/lsd_top.sv
/*
 Low supply detect control: control register, reference-stable flag,
 low supply flag with interrupt and sleep wake, trip input select.
 Assumes the analog divider, reference and comparator sit outside and
 present asynchronous levels; APB master on the same clock.
*/
// Design decisions made here: the address map and the APB slave port.
// Overview of operation
// - Read-only stable flag gates flag and interrupt
// - Enable bit powers detector up or down
// - Four-bit writable trip level field
// - No flag set before reference stable
// - Stability taken from reference, not counter
// - Detector runs in sleep and wakes
// - Vector taken on wake only if global
// - Reset clears enable, stable; level 0101
// - Comparator below set point sets flag
// - Level 1111 selects external trip input
`timescale 1ns/100ps
module lsd_top
    import lsd_pkg::*;
(
    // Clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst,
    input  wire logic        i_ce,
    // APB slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // Analog side
    input  wire logic        i_cmp_below,
    input  wire logic        i_ref_ready,
    output logic             o_detector_power_enable,
    output logic      [3:0]  o_trip_level_select,
    output logic             o_external_trip_input_sel,
    // Core side
    input  wire logic        i_sleeping,
    output logic             o_irq,
    output logic             o_wake,
    output logic             o_take_vector
);

    // Registers
    logic [3:0]              trip_level_select_reg;
    logic                    detector_power_enable_reg;
    logic [LSD_EVENTS_W-1:0] status_reg;
    logic [LSD_EVENTS_W-1:0] mask_reg;
    logic                    local_ie_reg;
    logic                    global_ie_reg;
    logic [31:0]             prdata_reg;
    logic                    pslverr_reg;
    logic                    pready_reg;
    logic                    irq_reg;
    logic                    wake_reg;
    logic                    vector_reg;
    logic                    ext_sel_reg;
    logic                    below_prev_reg;

    // Next values
    logic [31:0]             prdata_next;
    logic [LSD_EVENTS_W-1:0] status_next;

    lsd_apb_req_type req_w;
    lsd_analog_type  ana_sync_w;
    logic            wr_ctrl_w;
    logic            wr_status_w;
    logic            wr_mask_w;
    logic            wr_irqen_w;
    logic            rd_w;
    logic            unmapped_w;

    assign req_w = '{psel: i_psel, penable: i_penable, pwrite: i_pwrite,
                     paddr: i_paddr, pwdata: i_pwdata};

    lsd_apb_if u_apb (
        .i_req       (req_w),
        .o_wr_ctrl   (wr_ctrl_w),
        .o_wr_status (wr_status_w),
        .o_wr_mask   (wr_mask_w),
        .o_wr_irqen  (wr_irqen_w),
        .o_rd        (rd_w),
        .o_unmapped  (unmapped_w)
    );

    lsd_sync #(.WIDTH(2)) u_sync (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_ce      (i_ce),
        .i_async   ({i_cmp_below, i_ref_ready}),
        .o_sync    (ana_sync_w)
    );

    wire ref_stable_flag_w = detector_power_enable_reg & ana_sync_w.ref_ready;
    wire below_w           = detector_power_enable_reg & ana_sync_w.below;
    wire set_flag_w        = ref_stable_flag_w & below_w & ~below_prev_reg;
    wire irq_w             = |(status_reg & mask_reg);
    wire event_w           = status_reg[LSD_FLAG_BIT] & local_ie_reg;

    wire ext_sel_w = (trip_level_select_reg == LSD_LEVEL_EXTERN);

    wire [31:0] ctrl_rd_w = {26'h0, ref_stable_flag_w, detector_power_enable_reg,
                             trip_level_select_reg};

    // Zero extend an event field to a bus word
    function automatic logic [31:0] word_of(input logic [LSD_EVENTS_W-1:0] v);
        word_of = {{(32-LSD_EVENTS_W){1'b0}}, v};
    endfunction : word_of

    // Status set wins over clear
    always_comb begin
        status_next = status_reg;
        if (wr_status_w) begin
            status_next = status_reg & ~i_pwdata[LSD_EVENTS_W-1:0];
        end
        if (set_flag_w) begin
            status_next[LSD_FLAG_BIT] = 1'b1;
        end
    end

    always_comb begin
        prdata_next = 32'h0;
        case (i_paddr)
            LSD_CTRL_OFFSET:   prdata_next = ctrl_rd_w;
            LSD_STATUS_OFFSET: prdata_next = word_of(status_reg);
            LSD_MASK_OFFSET:   prdata_next = word_of(mask_reg);
            LSD_IRQEN_OFFSET:  prdata_next = {30'h0, global_ie_reg, local_ie_reg};
            default:           prdata_next = 32'h0;
        endcase
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            trip_level_select_reg     <= LSD_LEVEL_RESET;
            detector_power_enable_reg <= LSD_ENABLE_RESET;
        end else if (i_ce && wr_ctrl_w) begin
            trip_level_select_reg     <= i_pwdata[LSD_LEVEL_LSB +: LSD_LEVEL_W];
            detector_power_enable_reg <= i_pwdata[LSD_ENABLE_BIT];
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            status_reg     <= '0;
            mask_reg       <= {LSD_EVENTS_W{LSD_MASK_RESET}};
            local_ie_reg   <= 1'b0;
            global_ie_reg  <= 1'b0;
            below_prev_reg <= 1'b0;
        end else if (i_ce) begin
            status_reg     <= status_next;
            below_prev_reg <= below_w & ref_stable_flag_w;
            if (wr_mask_w) begin
                mask_reg <= i_pwdata[LSD_EVENTS_W-1:0];
            end
            if (wr_irqen_w) begin
                local_ie_reg  <= i_pwdata[LSD_LOCAL_IE_BIT];
                global_ie_reg <= i_pwdata[LSD_GLOBAL_IE_BIT];
            end
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            prdata_reg  <= 32'h0;
            pslverr_reg <= 1'b0;
            pready_reg  <= 1'b0;
            irq_reg     <= 1'b0;
            wake_reg    <= 1'b0;
            vector_reg  <= 1'b0;
            ext_sel_reg <= 1'b0;
        end else if (i_ce) begin
            if (rd_w) begin
                prdata_reg <= prdata_next;
            end
            pslverr_reg <= i_psel & ~i_penable & unmapped_w;
            pready_reg  <= 1'b1;
            irq_reg     <= irq_w & ref_stable_flag_w;
            wake_reg    <= i_sleeping & status_reg[LSD_FLAG_BIT];
            vector_reg  <= event_w & global_ie_reg;
            ext_sel_reg <= ext_sel_w;
        end
    end

    assign o_prdata                  = prdata_reg;
    assign o_pready                  = pready_reg;
    assign o_pslverr                 = pslverr_reg;
    assign o_detector_power_enable   = detector_power_enable_reg;
    assign o_trip_level_select       = trip_level_select_reg;
    assign o_external_trip_input_sel = ext_sel_reg;
    assign o_irq                     = irq_reg;
    assign o_wake                    = wake_reg;
    assign o_take_vector             = vector_reg;

    a_flag_needs_stable: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_ce && !ref_stable_flag_w && !status_reg[LSD_FLAG_BIT] && !wr_status_w) |=> !status_reg[LSD_FLAG_BIT])
        else $error("Flag set before reference stable");

    a_below_sets_flag: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_ce && set_flag_w) |=> status_reg[LSD_FLAG_BIT])
        else $error("Flag missed on comparator event");

    a_reset_level: assert property (@(posedge i_ref_clk)
        $fell(i_rst) |-> trip_level_select_reg == LSD_LEVEL_RESET && !detector_power_enable_reg)
        else $error("Wrong control state after reset");

    a_ext_select: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_ce && trip_level_select_reg == LSD_LEVEL_EXTERN) |=> o_external_trip_input_sel)
        else $error("External input not selected");

    a_enable_write: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_ce && wr_ctrl_w) |=> o_detector_power_enable == $past(i_pwdata[LSD_ENABLE_BIT]))
        else $error("Enable bit not stored");

    a_irq_stable: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_ce && !ref_stable_flag_w) |=> !o_irq)
        else $error("Interrupt while reference unstable");

    a_sleep_wake: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_ce && i_sleeping && status_reg[LSD_FLAG_BIT]) |=> o_wake)
        else $error("No wake on low supply in sleep");

    a_vector_global: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_ce && !global_ie_reg) |=> !o_take_vector)
        else $error("Vector taken without global enable");

    a_vector_taken: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_ce && event_w && global_ie_reg) |=> o_take_vector)
        else $error("Vector missed with enables set");

    a_irq_follows: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_ce && irq_w && ref_stable_flag_w) |=> o_irq)
        else $error("Interrupt missed for unmasked flag");

    a_flag_clear: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_ce && wr_status_w && i_pwdata[LSD_FLAG_BIT] && !set_flag_w) |=> !status_reg[LSD_FLAG_BIT])
        else $error("Flag not cleared by write of one");

    a_level_write: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_ce && wr_ctrl_w) |=> o_trip_level_select == $past(i_pwdata[LSD_LEVEL_LSB +: LSD_LEVEL_W]))
        else $error("Trip level not stored");

    a_ce_freeze: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        !i_ce |=> $stable(trip_level_select_reg) && $stable(detector_power_enable_reg))
        else $error("Control changed with clock enable low");

    sequence s_below_held;
        (i_ce && i_cmp_below) ##1 (i_ce && i_cmp_below);
    endsequence

    a_below_sync: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_below_held |=> ana_sync_w.below)
        else $error("Comparator level not synchronised");

    sequence s_ready_held;
        (i_ce && i_ref_ready) ##1 (i_ce && i_ref_ready);
    endsequence

    a_ready_stable: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_ready_held ##1 detector_power_enable_reg |-> ref_stable_flag_w)
        else $error("Stable flag not from reference");

    sequence s_sleep_event;
        (i_ce && i_sleeping && set_flag_w) ##1 (i_ce && i_sleeping);
    endsequence

    a_wake_event: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_sleep_event |=> o_wake)
        else $error("No wake after event in sleep");

endmodule : lsd_top

// File: hw/lsd_pkg.sv
/*
 Package for the low supply detect control block: register map, field
 positions, reset values and carrier types.
 Assumes an APB slave with 32-bit data and word-aligned registers.
*/
package lsd_pkg;

    // Register byte offsets
    localparam logic [7:0] LSD_CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] LSD_STATUS_OFFSET = 8'h04;
    localparam logic [7:0] LSD_MASK_OFFSET   = 8'h08;
    localparam logic [7:0] LSD_IRQEN_OFFSET  = 8'h0c;

    // Control register fields
    localparam int LSD_LEVEL_LSB  = 0;
    localparam int LSD_LEVEL_W    = 4;
    localparam int LSD_ENABLE_BIT = 4;
    localparam int LSD_STABLE_BIT = 5;

    // Status bits
    localparam int LSD_FLAG_BIT   = 0;
    localparam int LSD_EVENTS_W   = 1;

    // Irq enable register bits
    localparam int LSD_LOCAL_IE_BIT  = 0;
    localparam int LSD_GLOBAL_IE_BIT = 1;

    // Reset values and the external trip level code
    localparam logic [3:0] LSD_LEVEL_RESET   = 4'h5;
    localparam logic [3:0] LSD_LEVEL_EXTERN  = 4'hf;
    localparam logic       LSD_ENABLE_RESET  = 1'b0;
    localparam logic       LSD_MASK_RESET    = 1'b0;

    // Sync depth
    localparam int LSD_SYNC_STAGES = 2;

    typedef struct packed {
        logic       psel;
        logic       penable;
        logic       pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } lsd_apb_req_type;

    typedef struct packed {
        logic       below;
        logic       ref_ready;
    } lsd_analog_type;

endpackage : lsd_pkg

// File: hw/lsd_sync.sv
/*
 Two-stage synchroniser for a vector of asynchronous levels.
 Assumes the inputs are quasi-static levels from the analog side.
*/
`timescale 1ns/100ps
module lsd_sync
    import lsd_pkg::*;
#(
    parameter int WIDTH = 2
) (
    // Clock and reset
    input  wire logic             i_ref_clk,
    input  wire logic             i_rst,
    input  wire logic             i_ce,
    // Levels
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else if (i_ce) begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    assign o_sync = sync_reg;

endmodule : lsd_sync

// File: hw/lsd_apb_if.sv
/*
 APB slave decode for the low supply detect registers.
 Assumes zero wait states; pready is low in reset, then high from the first clock with i_ce.
*/
`timescale 1ns/100ps
module lsd_apb_if
    import lsd_pkg::*;
(
    // Bus request
    input  wire lsd_apb_req_type i_req,
    // Decoded strobes
    output logic                 o_wr_ctrl,
    output logic                 o_wr_status,
    output logic                 o_wr_mask,
    output logic                 o_wr_irqen,
    output logic                 o_rd,
    output logic                 o_unmapped
);

    wire access_w = i_req.psel & i_req.penable;
    wire hit_ctrl = (i_req.paddr == LSD_CTRL_OFFSET);
    wire hit_stat = (i_req.paddr == LSD_STATUS_OFFSET);
    wire hit_mask = (i_req.paddr == LSD_MASK_OFFSET);
    wire hit_ien  = (i_req.paddr == LSD_IRQEN_OFFSET);

    assign o_wr_ctrl   = access_w & i_req.pwrite & hit_ctrl;
    assign o_wr_status = access_w & i_req.pwrite & hit_stat;
    assign o_wr_mask   = access_w & i_req.pwrite & hit_mask;
    assign o_wr_irqen  = access_w & i_req.pwrite & hit_ien;
    assign o_rd        = i_req.psel & ~i_req.pwrite & ~i_req.penable;
    assign o_unmapped  = ~(hit_ctrl | hit_stat | hit_mask | hit_ien);

endmodule : lsd_apb_if

// File: verif/lsd_top_bench.sv
/*
 Self-checking bench for the low supply detect control block: APB master
 tasks, a small register model and stimulus for the analog and core inputs.
 Assumes lsd_pkg and lsd_top compiled first; one 50 MHz clock.
*/
`timescale 1ns/100ps
module lsd_top_bench;
    import lsd_pkg::*;

    logic        ref_clk, rst, ce, psel, penable, pwrite, cmp_below, ref_ready, sleeping;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, pwr_en, ext_sel, irq, wake, take_vec, err;
    logic [3:0]  level;
    logic [7:0]  lfsr;
    int          n_fail, num_checks, cycles, exp_lvl;
    logic [31:0] exp_q[$];

    lsd_top i_lsd_top (
        .i_ref_clk                 (ref_clk),
        .i_rst                     (rst),
        .i_ce                      (ce),
        .i_psel                    (psel),
        .i_penable                 (penable),
        .i_pwrite                  (pwrite),
        .i_paddr                   (paddr),
        .i_pwdata                  (pwdata),
        .o_prdata                  (prdata),
        .o_pready                  (pready),
        .o_pslverr                 (pslverr),
        .i_cmp_below               (cmp_below),
        .i_ref_ready               (ref_ready),
        .o_detector_power_enable   (pwr_en),
        .o_trip_level_select       (level),
        .o_external_trip_input_sel (ext_sel),
        .i_sleeping                (sleeping),
        .o_irq                     (irq),
        .o_wake                    (wake),
        .o_take_vector             (take_vec)
    );

    always #10 ref_clk = ~ref_clk;

    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        lfsr_next = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr_next

    // Model of the control word: level, enable, stable = enable and reference ready
    function automatic logic [31:0] ctrl_model(input int lvl, input int en, input int rdy);
        ctrl_model = 32'((lvl & 15) + ((en & 1) << LSD_ENABLE_BIT) + ((en & rdy & 1) << LSD_STABLE_BIT));
    endfunction : ctrl_model

    task automatic stop_test();
        if (n_fail == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // One APB transfer; answer taken at the access edge that sees pready high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) begin
            @(posedge ref_clk);
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic settle();
        repeat (8) @(posedge ref_clk);
    endtask : settle

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            stop_test();
        end
    end

    initial begin
        ref_clk = 0; rst = 1; ce = 1; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00;
        pwdata = 32'h0; cmp_below = 0; ref_ready = 0; sleeping = 0;
        n_fail = 0; num_checks = 0; cycles = 0; lfsr = 8'h25;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        apb(1'b0, LSD_CTRL_OFFSET, 32'h0);
        chk(rd, ctrl_model(5, 0, 0));
        chk({pwr_en, level, irq}, {1'b0, 4'h5, 1'b0});
        for (int i = 0; i < 16; i++) begin
            lfsr = lfsr_next(lfsr);
            exp_lvl = i;
            apb(1'b1, LSD_CTRL_OFFSET, {lfsr, lfsr, lfsr, lfsr[7:6], 2'b10, exp_lvl[3:0]});
            exp_q.push_back(ctrl_model(exp_lvl, 0, 0));
            apb(1'b0, LSD_CTRL_OFFSET, 32'h0);
            chk(rd, exp_q.pop_front());
            chk({ext_sel, level}, {exp_lvl == 15, exp_lvl[3:0]});
        end
        apb(1'b1, LSD_CTRL_OFFSET, 32'h03);
        apb(1'b1, LSD_IRQEN_OFFSET, 32'h0);
        apb(1'b1, LSD_CTRL_OFFSET, 32'h13);
        cmp_below <= 1'b1;
        settle();
        chk(pwr_en, 1'b1);
        apb(1'b0, LSD_CTRL_OFFSET, 32'h0);
        chk(rd, ctrl_model(3, 1, 0));
        apb(1'b0, LSD_STATUS_OFFSET, 32'h0);
        chk(rd, 32'h0);
        ref_ready <= 1'b1;
        settle();
        apb(1'b0, LSD_CTRL_OFFSET, 32'h0);
        chk(rd, ctrl_model(3, 1, 1));
        apb(1'b0, LSD_STATUS_OFFSET, 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, LSD_STATUS_OFFSET, 32'h1);
        apb(1'b0, LSD_STATUS_OFFSET, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, LSD_MASK_OFFSET, 32'h1);
        apb(1'b1, LSD_IRQEN_OFFSET, 32'h3);
        chk(irq, 1'b0);
        cmp_below <= 1'b0;
        sleeping  <= 1'b1;
        settle();
        cmp_below <= 1'b1;
        settle();
        chk({irq, wake, take_vec}, 3'b111);
        apb(1'b1, LSD_IRQEN_OFFSET, 32'h1);
        settle();
        chk({wake, take_vec}, 2'b10);
        apb(1'b1, LSD_MASK_OFFSET, 32'h0);
        settle();
        chk(irq, 1'b0);
        apb(1'b1, LSD_MASK_OFFSET, 32'h1);
        apb(1'b1, LSD_STATUS_OFFSET, 32'h1);
        settle();
        chk({irq, wake}, 2'b00);
        apb(1'b0, 8'h10, 32'h0);
        chk({err, rd}, {1'b1, 32'h0});
        apb(1'b0, LSD_MASK_OFFSET, 32'h0);
        chk({err, rd}, {1'b0, 32'h1});
        apb(1'b1, LSD_CTRL_OFFSET, 32'h03);
        settle();
        apb(1'b0, LSD_CTRL_OFFSET, 32'h0);
        chk({pwr_en, rd}, {1'b0, ctrl_model(3, 0, 1)});
        apb(1'b1, LSD_CTRL_OFFSET, 32'h1a);
        settle();
        ce <= 1'b0;
        apb(1'b1, LSD_CTRL_OFFSET, 32'h07);
        chk(pready, 1'b1);
        ce <= 1'b1;
        apb(1'b0, LSD_CTRL_OFFSET, 32'h0);
        chk({pwr_en, rd}, {1'b1, ctrl_model(10, 1, 1)});
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        apb(1'b0, LSD_CTRL_OFFSET, 32'h0);
        chk({pwr_en, irq, wake, rd}, {3'b000, ctrl_model(5, 0, 0)});
        stop_test();
    end
endmodule : lsd_top_bench
